// File: verilog/scan_afe_mode_config_regs.sv
/*
   Configuration register bank of a scanner analogue front end: setup,
   offset-level and gain registers behind a three-wire serial link, the
   colour auto-cycle counter and the sampling-mode decode.
   Assumes ref_clk stands in for the master clock, sck is the host's serial
   clock, and the include path reaches common/.
*/
`include "scan_afe_params.svh"

module scan_afe_mode_config_regs (
   // reference clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // serial control link
   input wire logic sck,
   input wire logic sdi,
   input wire logic sen,
   output logic sdo,
   output logic sdo_enable,
   // sampling pins
   input wire logic pixel_sync_pulse,
   input wire logic autocycle_pin,
   // register contents
   output logic [7:0] setup_power_sampling,
   output logic [7:0] setup_output_format,
   output logic [7:0] setup_clamp_channel,
   output logic [7:0] setup_colour_select,
   output logic [7:0] setup_sync_detect,
   output logic [7:0] setup_block_disable,
   output logic [7:0] offset_level_red,
   output logic [7:0] offset_level_green,
   output logic [7:0] offset_level_blue,
   output logic [7:0] gain_red,
   output logic [7:0] gain_green,
   output logic [7:0] gain_blue,
   // sampling control
   output logic [2:0] sampled_inputs,
   output scan_afe_pkg::colour_type input_select,
   output logic [7:0] active_offset,
   output logic [7:0] active_gain,
   output logic sample_strobe,
   output scan_afe_pkg::op_mode_type operating_mode
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // the reserved code 11 falls back to red
   function automatic scan_afe_pkg::colour_type to_colour(input logic [1:0] code);
      case (code)
         2'h1: return scan_afe_pkg::colour_green;
         2'h2: return scan_afe_pkg::colour_blue;
         default: return scan_afe_pkg::colour_red;
      endcase
   endfunction

   function automatic logic [2:0] colour_bit(input scan_afe_pkg::colour_type c);
      case (c)
         scan_afe_pkg::colour_green: return 3'h2;
         scan_afe_pkg::colour_blue: return 3'h4;
         default: return 3'h1;
      endcase
   endfunction

   function automatic logic [7:0] pick(input scan_afe_pkg::colour_type c,
                                       input logic [7:0] r,
                                       input logic [7:0] g,
                                       input logic [7:0] b);
      case (c)
         scan_afe_pkg::colour_green: return g;
         scan_afe_pkg::colour_blue: return b;
         default: return r;
      endcase
   endfunction

   function automatic scan_afe_pkg::op_mode_type decode_mode(input logic [7:0] ratio,
                                                             input logic line);
      if (ratio == `RATIO_PIXEL)
         return line ? scan_afe_pkg::mode_line : scan_afe_pkg::mode_pixel;
      if (ratio == `RATIO_FAST && line)
         return scan_afe_pkg::mode_fast;
      if (ratio == `RATIO_MAX && line)
         return scan_afe_pkg::mode_max;
      if (ratio >= `RATIO_SLOW_MIN && !ratio[0])
         return line ? scan_afe_pkg::mode_slow_line : scan_afe_pkg::mode_slow_pixel;
      return scan_afe_pkg::mode_unknown;
   endfunction

   // ----------------------------------------
   // link and pin crossings
   // ----------------------------------------
   logic [13:0] link_word;
   logic [7:0] readback_data;
   logic readback_toggle;
   logic sen_sync;
   logic sen_last;
   logic sync_sync;
   logic sync_last;
   logic cyc_sync;
   logic cyc_last;

   serial_link_port link_port (
      .sck(sck),
      .rst(rst),
      .sdi(sdi),
      .sdo(sdo),
      .sdo_enable(sdo_enable),
      .link_word(link_word),
      .readback_data(readback_data),
      .readback_toggle(readback_toggle)
   );

   signal_sync sen_cross (.clk(ref_clk), .rst(rst), .d(sen), .q(sen_sync));
   signal_sync sync_cross (.clk(ref_clk), .rst(rst), .d(pixel_sync_pulse), .q(sync_sync));
   signal_sync cyc_cross (.clk(ref_clk), .rst(rst), .d(autocycle_pin), .q(cyc_sync));

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sen_last <= 1'b0;
         sync_last <= 1'b0;
         cyc_last <= 1'b0;
      end else begin
         sen_last <= sen_sync;
         sync_last <= sync_sync;
         cyc_last <= cyc_sync;
      end
   end

   // ----------------------------------------
   // frame decode
   // ----------------------------------------
   logic frame_done;
   logic write_en;
   logic read_en;
   logic soft_reset;
   logic sync_rise;
   logic sync_fall;
   logic cyc_rise;
   logic [5:0] word_addr;
   logic [5:0] base_addr;
   logic [7:0] word_data;

   // link_word is stable while sen is high, so the sen edge hands it over
   assign frame_done = sen_sync & ~sen_last;
   assign word_addr = link_word[13:`WORD_ADDR_LO];
   assign word_data = link_word[7:0];
   assign base_addr = {word_addr[5], 1'b0, word_addr[3:0]};
   assign write_en = frame_done & ~word_addr[`READ_FLAG_BIT]; // R11 R12
   assign read_en = frame_done & word_addr[`READ_FLAG_BIT]; // R12
   assign soft_reset = write_en && word_addr == `OFF_SOFT_RESET; // R13
   assign sync_rise = sync_sync & ~sync_last;
   assign sync_fall = ~sync_sync & sync_last;
   assign cyc_rise = cyc_sync & ~cyc_last;

   // ----------------------------------------
   // setup registers
   // ----------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         setup_power_sampling <= `DEF_SETUP_POWER;
         setup_output_format <= `DEF_SETUP_FORMAT;
         setup_clamp_channel <= `DEF_SETUP_CLAMP;
         setup_colour_select <= `DEF_ZERO;
         setup_sync_detect <= `DEF_ZERO;
         setup_block_disable <= `DEF_ZERO;
      end else if (soft_reset) begin // R13
         setup_power_sampling <= `DEF_SETUP_POWER;
         setup_output_format <= `DEF_SETUP_FORMAT;
         setup_clamp_channel <= `DEF_SETUP_CLAMP;
         setup_colour_select <= `DEF_ZERO;
         setup_sync_detect <= `DEF_ZERO;
         setup_block_disable <= `DEF_ZERO;
      end else if (write_en) begin
         // fixed-zero bits are masked so they can never be set
         case (word_addr) // R11 R16
            `OFF_SETUP_POWER: setup_power_sampling <= word_data & `MASK_SETUP_POWER;
            `OFF_SETUP_FORMAT: setup_output_format <= word_data & `MASK_SETUP_FORMAT;
            `OFF_SETUP_CLAMP: setup_clamp_channel <= word_data;
            `OFF_SETUP_COLOUR: setup_colour_select <= word_data;
            `OFF_SETUP_SYNC: setup_sync_detect <= word_data & `MASK_SETUP_SYNC;
            `OFF_SETUP_DISABLE: setup_block_disable <= word_data & `MASK_SETUP_DISABLE;
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // offset-level and gain registers
   // ----------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         offset_level_red <= `DEF_LEVEL;
         offset_level_green <= `DEF_LEVEL;
         offset_level_blue <= `DEF_LEVEL;
         gain_red <= `DEF_GAIN;
         gain_green <= `DEF_GAIN;
         gain_blue <= `DEF_GAIN;
      end else if (soft_reset) begin // R13
         offset_level_red <= `DEF_LEVEL;
         offset_level_green <= `DEF_LEVEL;
         offset_level_blue <= `DEF_LEVEL;
         gain_red <= `DEF_GAIN;
         gain_green <= `DEF_GAIN;
         gain_blue <= `DEF_GAIN;
      end else if (write_en) begin
         case (word_addr) // R11
            `OFF_LEVEL_RED: offset_level_red <= word_data;
            `OFF_LEVEL_GREEN: offset_level_green <= word_data;
            `OFF_LEVEL_BLUE: offset_level_blue <= word_data;
            `OFF_LEVEL_ALL: begin // R16
               offset_level_red <= word_data;
               offset_level_green <= word_data;
               offset_level_blue <= word_data;
            end
            `OFF_GAIN_RED: gain_red <= word_data;
            `OFF_GAIN_GREEN: gain_green <= word_data;
            `OFF_GAIN_BLUE: gain_blue <= word_data;
            `OFF_GAIN_ALL: begin // R16
               gain_red <= word_data;
               gain_green <= word_data;
               gain_blue <= word_data;
            end
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // read-back
   // ----------------------------------------
   logic [7:0] read_value;

   // write-only, reserved and unmapped locations answer zero
   always_comb begin
      case (base_addr) // R12 R16
         `OFF_SETUP_POWER: read_value = setup_power_sampling;
         `OFF_SETUP_FORMAT: read_value = setup_output_format;
         `OFF_SETUP_CLAMP: read_value = setup_clamp_channel;
         `OFF_SETUP_COLOUR: read_value = setup_colour_select;
         `OFF_REVISION: read_value = `REVISION_VALUE;
         `OFF_SETUP_SYNC: read_value = setup_sync_detect;
         `OFF_SETUP_DISABLE: read_value = setup_block_disable;
         `OFF_LEVEL_RED: read_value = offset_level_red;
         `OFF_LEVEL_GREEN: read_value = offset_level_green;
         `OFF_LEVEL_BLUE: read_value = offset_level_blue;
         `OFF_GAIN_RED: read_value = gain_red;
         `OFF_GAIN_GREEN: read_value = gain_green;
         `OFF_GAIN_BLUE: read_value = gain_blue;
         default: read_value = `DEF_ZERO;
      endcase
   end

   // the byte is held until the next read so the link side sees it stable
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         readback_data <= `DEF_ZERO;
         readback_toggle <= 1'b0;
      end else if (read_en) begin // R12
         readback_data <= read_value;
         readback_toggle <= ~readback_toggle;
      end
   end

   // ----------------------------------------
   // colour auto-cycle counter
   // ----------------------------------------
   scan_afe_pkg::colour_type cycle_colour;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cycle_colour <= scan_afe_pkg::colour_red;
      end else if (soft_reset || (write_en && word_addr == `OFF_CYCLE_RESET)) begin
         cycle_colour <= scan_afe_pkg::colour_red; // R13 R14
      end else if (cyc_rise && setup_colour_select[`CYCLE_PIN_BIT]) begin
         case (cycle_colour)
            scan_afe_pkg::colour_red: cycle_colour <= scan_afe_pkg::colour_green;
            scan_afe_pkg::colour_green: cycle_colour <= scan_afe_pkg::colour_blue;
            default: cycle_colour <= scan_afe_pkg::colour_red;
         endcase
      end
   end

   // ----------------------------------------
   // input and channel selection
   // ----------------------------------------
   scan_afe_pkg::colour_type next_input_select;
   scan_afe_pkg::colour_type next_gain_colour;
   logic [2:0] next_sampled;
   logic line_mode;
   logic by_line;
   logic by_cycle;

   assign by_line = setup_colour_select[`LINE_BIT];
   assign by_cycle = setup_colour_select[`CYCLE_PIN_BIT];
   assign line_mode = setup_power_sampling[`MONO_BIT] | by_line;

   always_comb begin
      if (by_line) begin
         next_gain_colour = by_cycle ? cycle_colour
                          : to_colour(setup_colour_select[`INTERNAL_COLOUR_SELECT_LO +: 2]);
         if (setup_colour_select[`FORCE_EN_BIT])
            next_input_select = to_colour(setup_colour_select[`FM_LO +: 2]);
         else
            next_input_select = next_gain_colour;
      end else if (setup_power_sampling[`MONO_BIT]) begin
         next_input_select = to_colour(setup_clamp_channel[`MONO_INPUT_SELECT_LO +: 2]); // R8
         next_gain_colour = next_input_select;
      end else begin
         next_input_select = scan_afe_pkg::colour_red;
         next_gain_colour = scan_afe_pkg::colour_red;
      end
      // one input in line modes, all three in pixel modes
      next_sampled = line_mode ? colour_bit(next_input_select) : 3'h7; // R1 R3
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         input_select <= scan_afe_pkg::colour_red;
         sampled_inputs <= 3'h7;
         active_offset <= `DEF_LEVEL;
         active_gain <= `DEF_GAIN;
      end else begin
         input_select <= next_input_select;
         sampled_inputs <= next_sampled; // R1 R3
         active_offset <= pick(next_gain_colour, offset_level_red,
                               offset_level_green, offset_level_blue); // R2
         active_gain <= pick(next_gain_colour, gain_red, gain_green, gain_blue); // R2
      end
   end

   // ----------------------------------------
   // sample strobe and mode decode
   // ----------------------------------------
   logic [7:0] period_count;
   logic [7:0] sync_ratio;

   // same strobe timing whatever the correlated-sampling bit says
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) sample_strobe <= 1'b0;
      else sample_strobe <= sync_fall; // R10
   end

   // the period saturates, so very slow syncs decode as unknown
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         period_count <= 8'h00;
         sync_ratio <= 8'h00;
      end else if (sync_rise) begin
         period_count <= 8'h01;
         sync_ratio <= period_count;
      end else if (period_count != 8'hFF) begin
         period_count <= period_count + 8'h01;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) operating_mode <= scan_afe_pkg::mode_unknown;
      else operating_mode <= decode_mode(sync_ratio, line_mode);
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_write_lands: assert property ( // R11
      write_en && word_addr == `OFF_GAIN_GREEN |=> gain_green == $past(word_data))
      else $error("gain write did not land");
   a_read_no_write: assert property ( // R12
      read_en |=> $stable(gain_green) && $stable(setup_clamp_channel)
                  && readback_toggle != $past(readback_toggle))
      else $error("read-back altered a register or gave no answer");
   a_soft_defaults: assert property ( // R13
      soft_reset |=> setup_power_sampling == `DEF_SETUP_POWER
                     && offset_level_blue == `DEF_LEVEL && gain_red == `DEF_GAIN)
      else $error("software reset left a register changed");
   a_cycle_home: assert property ( // R14
      write_en && word_addr == `OFF_CYCLE_RESET
      |=> cycle_colour == scan_afe_pkg::colour_red)
      else $error("auto-cycle reset did not return to red");
   a_all_fanout: assert property ( // R16
      write_en && word_addr == `OFF_LEVEL_ALL
      |=> offset_level_red == $past(word_data) && offset_level_blue == $past(word_data)
          && offset_level_green == $past(word_data))
      else $error("combined offset write missed a channel");
   a_reserved_zero: assert property ( // R16
      read_en && base_addr == `OFF_RSVD_A |=> readback_data == `DEF_ZERO)
      else $error("reserved register read back non-zero");
   a_pixel_all: assert property ( // R1
      !line_mode |=> sampled_inputs == 3'h7)
      else $error("pixel mode is not sampling all inputs");
   a_line_single: assert property ( // R3
      line_mode |=> $onehot(sampled_inputs))
      else $error("line mode samples other than one input");
   a_mono_mono_input_select: assert property ( // R8
      setup_power_sampling[`MONO_BIT] && !by_line
      |=> sampled_inputs == colour_bit(to_colour($past(setup_clamp_channel[7:6]))))
      else $error("mono input does not follow the channel field");
   a_strobe_time: assert property ( // R10
      sync_fall |=> sample_strobe ##1 !sample_strobe)
      else $error("sample strobe misplaced");
   a_gain_pick: assert property ( // R2
      line_mode && next_gain_colour == scan_afe_pkg::colour_blue
      |=> active_gain == $past(gain_blue))
      else $error("active gain is not the selected channel");

   c_pixel_mode: cover property (operating_mode == scan_afe_pkg::mode_pixel);
   c_read_back: cover property (read_en ##[1:40] sen_sync);
   c_cycle_step: cover property (cyc_rise && by_cycle ##1
                                 cycle_colour == scan_afe_pkg::colour_green);

endmodule

// File: common/scan_afe_params.svh
/*
   Constants of the scanner front-end configuration bank: register offsets,
   reset values, writable-bit masks, field positions and sync ratios.
   Assumes it is included by bare name, before any module that uses it.
*/
// How it works
// R1: pixel mode samples all three inputs together
// R2: pixel mode applies per-channel gain and offset; the code keeps active_gain and active_offset on red in pixel modes
// R3: line mode samples exactly one input continuously
// R4: fast mode uses 3:1 ratio, host settings
// R5: maximum-speed mode uses 2:1 ratio, no correlated
// R6: slow modes use even ratio of eight+
// R7: host keeps master clock at most 24MHz
// R8: mono input comes from third byte 7:6
// R9: host sets colour line bit for line colour
// R10: sample timing ignores correlated sampling setting
// R11: each written code lands at its address
// R12: address bit 4 set requests read-back only
// R13: software-reset write restores every cell default
// R14: auto-cycle reset write returns counter to red
// R15: host sets max-speed bit only in mode 4
// R16: combined writes fan out; reserved stays zero
`ifndef SCAN_AFE_PARAMS_SVH
`define SCAN_AFE_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFF_SETUP_POWER 6'h01
`define OFF_SETUP_FORMAT 6'h02
`define OFF_SETUP_CLAMP 6'h03
`define OFF_SOFT_RESET 6'h04
`define OFF_CYCLE_RESET 6'h05
`define OFF_SETUP_COLOUR 6'h06
`define OFF_REVISION 6'h07
`define OFF_SETUP_SYNC 6'h08
`define OFF_SETUP_DISABLE 6'h09
`define OFF_RSVD_A 6'h0A
`define OFF_LEVEL_RED 6'h20
`define OFF_LEVEL_GREEN 6'h21
`define OFF_LEVEL_BLUE 6'h22
`define OFF_LEVEL_ALL 6'h23
`define OFF_GAIN_RED 6'h28
`define OFF_GAIN_GREEN 6'h29
`define OFF_GAIN_BLUE 6'h2A
`define OFF_GAIN_ALL 6'h2B

// ----------------------------------------
// reset values and writable bits
// ----------------------------------------
`define DEF_SETUP_POWER 8'h03
`define DEF_SETUP_FORMAT 8'h20
`define DEF_SETUP_CLAMP 8'h1F
`define DEF_ZERO 8'h00
`define DEF_LEVEL 8'h80
`define DEF_GAIN 8'h00
`define MASK_SETUP_POWER 8'h7F
`define MASK_SETUP_FORMAT 8'hEF
`define MASK_SETUP_SYNC 8'h1F
`define MASK_SETUP_DISABLE 8'h0F
// arbitrary identification value
`define REVISION_VALUE 8'hA7

// ----------------------------------------
// field positions
// ----------------------------------------
`define READ_FLAG_BIT 4
`define CDS_BIT 1
`define MONO_BIT 2
`define LINE_BIT 0
`define CYCLE_PIN_BIT 1
`define FORCE_EN_BIT 2
`define INTERNAL_COLOUR_SELECT_LO 4
`define FM_LO 6
`define MONO_INPUT_SELECT_LO 6

// ----------------------------------------
// link word and sync ratios
// ----------------------------------------
`define WORD_ADDR_LO 8
`define READ_BITS 4'h8
`define RATIO_PIXEL 8'h06
`define RATIO_FAST 8'h03
`define RATIO_MAX 8'h02
`define RATIO_SLOW_MIN 8'h08

`endif

// File: common/scan_afe_pkg.sv
/*
   Types shared by the front-end configuration bank.
   Assumes nothing beyond a SystemVerilog compiler.
*/
package scan_afe_pkg;

   // input channel codes follow the register field codes
   typedef enum logic [1:0] {
      colour_red,
      colour_green,
      colour_blue,
      colour_none
   } colour_type;

   // the position of each name is the sampling mode number
   typedef enum logic [2:0] {
      mode_unknown,
      mode_pixel,
      mode_line,
      mode_fast,
      mode_max,
      mode_slow_pixel,
      mode_slow_line
   } op_mode_type;

endpackage

// File: verilog/signal_sync.sv
/*
   Two-flop synchroniser for one level.
   Assumes d is asynchronous to clk; only q may be read by other logic.
*/
module signal_sync (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // level in and out
   input wire logic d,
   output logic q
);

   logic meta;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= 1'b0;
         q <= 1'b0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end

endmodule

// File: verilog/serial_link_port.sv
/*
   Serial control link end, clocked by the link clock sck.
   Assumes the host keeps sck still while sen is pulsed and for a few
   reference clocks after, so link_word is quasi-static when captured.
*/
`include "scan_afe_params.svh"

module serial_link_port (
   // link clock and reset
   input wire logic sck,
   input wire logic rst,
   // serial pins
   input wire logic sdi,
   output logic sdo,
   output logic sdo_enable,
   // towards the register side
   output logic [13:0] link_word,
   input wire logic [7:0] readback_data,
   input wire logic readback_toggle
);

   logic toggle_meta;
   logic toggle_sync;
   logic toggle_seen;
   logic [7:0] out_shift;
   logic [3:0] out_count;

   // address then data, msb first, taken on the rising edge
   always_ff @(posedge sck or posedge rst) begin
      if (rst) link_word <= 14'h0000;
      else link_word <= {link_word[12:0], sdi};
   end

   // read-back byte crosses by toggle; it goes out on falling edges
   always_ff @(negedge sck or posedge rst) begin
      if (rst) begin
         toggle_meta <= 1'b0;
         toggle_sync <= 1'b0;
         toggle_seen <= 1'b0;
         out_shift <= 8'h00;
         out_count <= 4'h0;
         sdo_enable <= 1'b0;
      end else begin
         toggle_meta <= readback_toggle;
         toggle_sync <= toggle_meta;
         toggle_seen <= toggle_sync;
         if (toggle_sync != toggle_seen) begin
            out_shift <= readback_data;
            out_count <= `READ_BITS;
            sdo_enable <= 1'b1;
         end else if (out_count != 4'h0) begin
            out_shift <= {out_shift[6:0], 1'b0};
            out_count <= out_count - 4'h1;
            if (out_count == 4'h1) sdo_enable <= 1'b0;
         end
      end
   end

   assign sdo = out_shift[7];

endmodule

// File: tb/host_link_model.sv
/*
   Host controller model on the three-wire link: write frames, the
   frame-end strobe and read-back collection.
   Assumes a reference clock of 8 ns for the strobe width and spacing.
*/
module host_link_model (
   // link pins
   output logic sck,
   output logic sdi,
   output logic sen,
   input wire logic sdo,
   input wire logic sdo_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rx = 8'h00;
   initial begin
      sck = 1'b0;
      sdi = 1'b0;
      sen = 1'b0;
   end
   // sampled on the rise, half a period after the device moves sdo
   always @(posedge sck) if (sdo_enable) rx <= {rx[6:0], sdo};
   // sck stands still outside frames; released sdi is inverted, not held
   task automatic send(input logic [5:0] addr, input logic [7:0] data);
      logic [13:0] word;
      word = {addr, data};
      for (int i = 13; i >= 0; i--) begin
         sdi = word[i];
         #15 sck = 1'b1;
         #15 sck = 1'b0;
      end
      sdi = ~sdi;
      #10 sen = 1'b1;
      #40 sen = 1'b0;
      #40;
   endtask
   // the byte emerges during the following frame, a harmless reserved write
   task automatic read(input logic [5:0] addr, output logic [7:0] data);
      send(addr | 6'h10, 8'h00);
      send(6'h0A, 8'h00);
      data = rx;
   endtask
endmodule

// File: tb/tb_scan_afe_mode_config_regs.sv
/*
   Self-checking bench of the configuration bank: register table over the
   serial link, combined writes, resets, mode decode and input selection.
   Assumes the include path reaches common/.
*/
`include "scan_afe_params.svh"
module tb_scan_afe_mode_config_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic pixel_sync_pulse = 1'b0;
   logic autocycle_pin = 1'b0;
   logic sck, sdi, sen, sdo, sdo_enable;
   logic [2:0] sampled_inputs;
   scan_afe_pkg::colour_type input_select;
   scan_afe_pkg::op_mode_type operating_mode;
   logic [7:0] active_offset, active_gain;
   logic sample_strobe;
   int gap = 0;
   int since = 0;
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;
   int period = 0;
   int phase = 0;
   logic [5:0] adr[12] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09,
      6'h0A, 6'h20, 6'h28};
   logic [7:0] dflt[12] = '{8'h03, 8'h20, 8'h1F, 8'h00, 8'h00, 8'h00, `REVISION_VALUE, 8'h00,
      8'h00, 8'h00, 8'h80, 8'h00};
   logic [7:0] wexp[12] = '{8'h7F, 8'hEF, 8'hFF, 8'h00, 8'h00, 8'hFF, `REVISION_VALUE, 8'h1F,
      8'h0F, 8'h00, 8'hFF, 8'hFF};
   logic [7:0] mset[8] = '{8'h03, 8'h01, 8'h07, 8'h05, 8'h07, 8'h45, 8'h03, 8'h07};
   int mper[8] = '{6, 6, 6, 6, 3, 2, 8, 10};
   logic [7:0] mexp[8] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};
   scan_afe_mode_config_regs dut (.ref_clk, .rst, .sck, .sdi, .sen, .sdo, .sdo_enable,
      .pixel_sync_pulse, .autocycle_pin, .setup_power_sampling(), .setup_output_format(),
      .setup_clamp_channel(), .setup_colour_select(), .setup_sync_detect(),
      .setup_block_disable(), .offset_level_red(), .offset_level_green(),
      .offset_level_blue(), .gain_red(), .gain_green(), .gain_blue(), .sampled_inputs,
      .input_select, .active_offset, .active_gain, .sample_strobe, .operating_mode);
   host_link_model host (.sck, .sdi, .sen, .sdo, .sdo_enable);
   always #4 ref_clk = ~ref_clk;
   // cycles between the last two sample strobes, looked at away from the launch edge
   always @(negedge ref_clk) begin
      since++;
      if (sample_strobe) begin
         gap = since;
         since = 0;
      end
   end
   // one-cycle pixel sync every period cycles; period 0 keeps it low
   always @(posedge ref_clk) begin
      #1;
      phase = (phase + 1 >= period) ? 0 : phase + 1;
      pixel_sync_pulse = (period != 0) && (phase == 0);
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
      logic [7:0] v;
      host.read(a, v);
      chk(v, exp);
   endtask
   task automatic print_verdict();
      $display("compares %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         print_verdict();
      end
   end
   initial begin
      repeat (3) @(posedge ref_clk);
      #1 rst = 1'b0;
      repeat (2) @(posedge ref_clk);
      for (int i = 0; i < 12; i++) rchk(adr[i], dflt[i]);
      // all ones everywhere but the soft reset shows the writable bits
      for (int i = 0; i < 12; i++) if (i != 3) host.send(adr[i], 8'hFF);
      for (int i = 0; i < 12; i++) rchk(adr[i], wexp[i]);
      host.send(6'h04, 8'h5A);
      for (int i = 0; i < 12; i++) rchk(adr[i], dflt[i]);
      host.send(6'h23, 8'h5A);
      host.send(6'h2B, 8'hC3);
      host.send(6'h30, 8'h11);
      for (int c = 0; c < 3; c++) rchk(6'(32 + c), 8'h5A);
      for (int c = 0; c < 3; c++) rchk(6'(40 + c), 8'hC3);
      host.send(6'h03, 8'h0F);
      for (int i = 0; i < 8; i++) begin
         host.send(6'h01, mset[i]);
         period = mper[i];
         repeat (40) @(posedge ref_clk);
         chk({5'h00, operating_mode}, mexp[i]);
         chk({5'h00, sampled_inputs}, (mexp[i] == 1 || mexp[i] == 5) ? 8'h07 : 8'h01);
         chk(8'(gap), 8'(mper[i]));
      end
      host.send(6'h03, 8'h8F);
      repeat (6) @(posedge ref_clk);
      chk({6'h00, input_select}, 8'h02);
      chk({5'h00, sampled_inputs}, 8'h04);
      host.send(6'h29, 8'h3C);
      host.send(6'h01, 8'h03);
      host.send(6'h06, 8'h03);
      @(posedge ref_clk);
      #1 autocycle_pin = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1 autocycle_pin = 1'b0;
      repeat (4) @(posedge ref_clk);
      chk({6'h00, input_select}, 8'h01);
      chk(active_gain, 8'h3C);
      chk(active_offset, 8'h5A);
      host.send(6'h05, 8'h00);
      repeat (4) @(posedge ref_clk);
      chk({6'h00, input_select}, 8'h00);
      chk(active_gain, 8'hC3);
      print_verdict();
   end
endmodule
